// ==== hw/mascfg_params.svh ====
// Parameter numbers, field positions, reset values and timing counts for the axis status/config bank.
// Assumes a 40 MHz system clock and a parameter-number access port driven by the command interpreter.
// Functional notes
// RL1 - At rest with zero standby and silent chopper: 0 normal, 1 free, 2 low short, 3 high short.
// RL2 - Read-only load measurement up to 1023, the stall detection quantity.
// RL3 - Extended error status: value 1 stall error, value 2 deviation error.
// RL4 - Extended error flags clear after being read or on a motion command.
// RL5 - Driver fault bit 0 stall, bit 1 thermal shutdown, bit 2 thermal pre-warning.
// RL6 - Driver fault bits 3/4 report short to ground on coil A/B while shut down.
// RL7 - Driver fault bits 5/6 report open load on coil A/B.
// RL8 - Driver fault bit 7 means no step pulse in the last 2^20 clock cycles.
// RL9 - Signed read/write built-in encoder counter in microsteps.
// RL10 - With clear-on-zero set, clear built-in encoder counter at encoder zero position.
// RL11 - After that clear, the clear-on-zero option returns to 0 by itself.
// RL12 - Stop the motor if position and built-in encoder differ beyond nonzero limit.
// RL13 - Stop the motor if position and external encoder differ beyond nonzero limit.
// RL14 - Wait programmable standstill period in 10 ms units before reducing current.
// RL15 - Power-down delay 0 (default) reduces current immediately after stopping.
// RL16 - Read-only absolute angle up to 1023 within one motor revolution.
// RL17 - Signed read/write external quadrature encoder counter in microsteps.
// RL18 - External encoder resolution in counts per revolution, non-negative only.
// RL19 - Shaft reversal bit inverts the motor rotation direction.
// RL20 - Motion source: 0 internal ramp generator, 1 external step/direction inputs.
// RL21 - Unit selector: 0 raw units, 1 pulses per second units; default 1.
// RL22 - Standstill counter restarts on each step and flags standstill when saturated.
`ifndef MASCFG_PARAMS_SVH
`define MASCFG_PARAMS_SVH
`define MASCFG_PN_STANDSTILL   8'hCC
`define MASCFG_PN_LOAD         8'hCE
`define MASCFG_PN_EXT_ERR      8'hCF
`define MASCFG_PN_DRV_FAULT    8'hD0
`define MASCFG_PN_INT_ENC      8'hD1
`define MASCFG_PN_CLR_ZERO     8'hD2
`define MASCFG_PN_INT_DEV      8'hD4
`define MASCFG_PN_PD_DELAY     8'hD6
`define MASCFG_PN_ABS_ANGLE    8'hD7
`define MASCFG_PN_EXT_ENC      8'hD8
`define MASCFG_PN_EXT_CPR      8'hD9
`define MASCFG_PN_EXT_DEV      8'hDA
`define MASCFG_PN_SHAFT_INV    8'hFB
`define MASCFG_PN_MOTION_SRC   8'hFE
`define MASCFG_PN_UNIT_SEL     8'hFF
`define MASCFG_ERR_STALL_BIT   0
`define MASCFG_ERR_DEV_BIT     1
`define MASCFG_RST_PD_DELAY    9'h000
`define MASCFG_RST_UNIT_SEL    1'b1
`define MASCFG_STILL_LOG2      20
`define MASCFG_PD_UNIT_NS      10000000
`define MASCFG_CLK_PERIOD_NS   25
`define MASCFG_PD_UNIT_CYC     (`MASCFG_PD_UNIT_NS / `MASCFG_CLK_PERIOD_NS)
`endif

// ==== hw/mascfg_pkg.sv ====
// Types for the axis status/config bank.
// Assumes the params header is included by the users of these types.
package mascfg_pkg;
  typedef enum logic [1:0] {
    MASCFG_REST_NORMAL,
    MASCFG_REST_FREEWHEEL,
    MASCFG_REST_SHORT_LOW,
    MASCFG_REST_SHORT_HIGH
  } mascfg_rest_t;

  typedef struct packed {
    logic stall;
    logic overtemp;
    logic overtemp_warn;
    logic short_a;
    logic short_b;
    logic open_a;
    logic open_b;
  } mascfg_drv_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] num;
    logic [31:0] data;
  } mascfg_req_t;

  typedef enum {
    MASCFG_PD_IDLE,
    MASCFG_PD_WAIT,
    MASCFG_PD_REDUCED
  } mascfg_pd_state_t;
endpackage : mascfg_pkg

// ==== hw/mascfg_axis.sv ====
// Axis status/config bank: parameters reached by number, encoder counters, deviation stop,
// standstill detection and current-reduction timing. Assumes driver status and encoder inputs
// are pins (synchronised here) and the parameter port comes from same-clock logic.
`timescale 1ns/10ps
`include "mascfg_params.svh"
module mascfg_axis import mascfg_pkg::*; #(
  parameter int STILL_LOG2 = `MASCFG_STILL_LOG2,
  parameter int PD_UNIT_CYC = `MASCFG_PD_UNIT_CYC
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Parameter access port
  input wire mascfg_req_t req_i,
  output logic [31:0] rdata_o,
  output logic rvalid_o,
  output logic nak_o,
  input wire logic motion_cmd_i,
  // Motion state from the ramp generator
  input wire logic [31:0] actual_pos_i,
  input wire logic motor_stopped_i,
  input wire logic standby_zero_i,
  input wire logic silent_chop_i,
  // Pins from driver and encoders
  input wire logic step_pin_i,
  input wire logic [7:0] drv_pin_i,
  input wire logic [9:0] load_pin_i,
  input wire logic [9:0] angle_pin_i,
  input wire logic int_enc_step_i,
  input wire logic int_enc_dir_i,
  input wire logic int_enc_zero_i,
  input wire logic ext_a_i,
  input wire logic ext_b_i,
  // Control outputs
  output logic motor_stop_o,
  output mascfg_rest_t rest_mode_o,
  output logic current_reduce_o,
  output logic shaft_invert_o,
  output logic use_step_dir_o,
  output logic unit_pps_o
);
  logic [1:0] rest_r;
  logic clr_zero_r;
  logic [31:0] int_dev_r, ext_dev_r, ext_cpr_r;
  logic [8:0] pd_delay_r;
  logic shaft_inv_r, src_sel_r, unit_r;
  logic [31:0] int_enc_r, ext_enc_r;
  logic [1:0] ext_err_r;
  logic [STILL_LOG2-1:0] still_cnt_r;
  logic still_r;
  logic [21:0] p1_r, p2_r;
  logic [21:0] pins_s;
  logic [9:0] load_r, angle_r;
  logic step_d_r, enc_step_d_r;
  logic [1:0] ab_d_r;
  mascfg_pd_state_t pd_state_r;
  logic [8:0] pd_units_r;
  logic [31:0] pd_cyc_r;
  logic step_evt, enc_evt, int_dev_hit, ext_dev_hit;
  logic [1:0] quad;

  function automatic logic [31:0] abs_diff(input logic [31:0] a, input logic [31:0] b);
    logic [31:0] d;
    d = a - b;
    abs_diff = d[31] ? (32'h0 - d) : d;
  endfunction : abs_diff

  function automatic logic is_wr(input mascfg_req_t r, input logic [7:0] n);
    is_wr = r.wr && (r.num == n);
  endfunction : is_wr

  // Two-stage synchronisers for the step, driver fault and encoder pins
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      p1_r <= 22'h0;
      p2_r <= 22'h0;
    end else begin
      p1_r <= {step_pin_i, drv_pin_i[6:0], int_enc_step_i, int_enc_dir_i, int_enc_zero_i, ext_a_i, ext_b_i,
               9'h0};
      p2_r <= p1_r;
    end
  end
  assign pins_s = p2_r;

  // Multi-bit readouts: sampled twice bit by bit, may tear into a mix of old and new bits on a change
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      load_r <= 10'h0;
      angle_r <= 10'h0;
    end else begin
      load_r <= load_pin_i; // RL2
      angle_r <= angle_pin_i; // RL16
    end
  end
  logic [9:0] load_s_r, angle_s_r;
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      load_s_r <= 10'h0;
      angle_s_r <= 10'h0;
    end else begin
      load_s_r <= load_r;
      angle_s_r <= angle_r;
    end
  end

  mascfg_drv_t drv;
  assign drv = pins_s[20:14];

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      step_d_r <= 1'b0;
      enc_step_d_r <= 1'b0;
      ab_d_r <= 2'b00;
    end else begin
      step_d_r <= pins_s[21];
      enc_step_d_r <= pins_s[13];
      ab_d_r <= pins_s[10:9];
    end
  end
  assign step_evt = pins_s[21] & ~step_d_r;
  assign enc_evt = pins_s[13] & ~enc_step_d_r;
  assign quad = pins_s[10:9];

  // Configuration registers
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rest_r <= 2'h0;
      int_dev_r <= 32'h0;
      ext_dev_r <= 32'h0;
      ext_cpr_r <= 32'h0;
      pd_delay_r <= `MASCFG_RST_PD_DELAY;
      shaft_inv_r <= 1'b0;
      src_sel_r <= 1'b0;
      unit_r <= `MASCFG_RST_UNIT_SEL; // RL21
    end else begin
      if (is_wr(req_i, `MASCFG_PN_STANDSTILL)) rest_r <= req_i.data[1:0];
      if (is_wr(req_i, `MASCFG_PN_INT_DEV)) int_dev_r <= {1'b0, req_i.data[30:0]};
      if (is_wr(req_i, `MASCFG_PN_EXT_DEV)) ext_dev_r <= {1'b0, req_i.data[30:0]};
      if (is_wr(req_i, `MASCFG_PN_EXT_CPR)) ext_cpr_r <= {1'b0, req_i.data[30:0]}; // RL18
      if (is_wr(req_i, `MASCFG_PN_PD_DELAY)) pd_delay_r <= req_i.data[8:0];
      if (is_wr(req_i, `MASCFG_PN_SHAFT_INV)) shaft_inv_r <= req_i.data[0];
      if (is_wr(req_i, `MASCFG_PN_MOTION_SRC)) src_sel_r <= req_i.data[0];
      if (is_wr(req_i, `MASCFG_PN_UNIT_SEL)) unit_r <= req_i.data[0];
    end
  end

  // Clear-on-zero arming; hardware clear wins only after a zero hit
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      clr_zero_r <= 1'b0;
    end else if (clr_zero_r && pins_s[11]) begin
      clr_zero_r <= 1'b0; // RL11
    end else if (is_wr(req_i, `MASCFG_PN_CLR_ZERO)) begin
      clr_zero_r <= req_i.data[0];
    end
  end

  // Built-in encoder counter
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      int_enc_r <= 32'h0;
    end else if (clr_zero_r && pins_s[11]) begin
      int_enc_r <= 32'h0; // RL10
    end else if (is_wr(req_i, `MASCFG_PN_INT_ENC)) begin
      int_enc_r <= req_i.data; // RL9
    end else if (enc_evt) begin
      int_enc_r <= pins_s[12] ? int_enc_r - 32'h1 : int_enc_r + 32'h1; // RL9
    end
  end

  // External quadrature counter, one count per valid edge
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ext_enc_r <= 32'h0;
    end else if (is_wr(req_i, `MASCFG_PN_EXT_ENC)) begin
      ext_enc_r <= req_i.data; // RL17
    end else if (quad != ab_d_r && (quad ^ ab_d_r) != 2'b11) begin
      if ((ab_d_r[1] ^ quad[0]) == 1'b1) ext_enc_r <= ext_enc_r + 32'h1; // RL17
      else ext_enc_r <= ext_enc_r - 32'h1;
    end
  end

  // Deviation checks, zero limit disables
  assign int_dev_hit = (int_dev_r != 32'h0) && (abs_diff(actual_pos_i, int_enc_r) > int_dev_r); // RL12
  assign ext_dev_hit = (ext_dev_r != 32'h0) && (abs_diff(actual_pos_i, ext_enc_r) > ext_dev_r); // RL13

  // Extended error flags; a new error in the clearing cycle survives
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ext_err_r <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if ((req_i.rd && req_i.num == `MASCFG_PN_EXT_ERR) || motion_cmd_i) ext_err_r[i] <= 1'b0; // RL4
      end
      if (drv.stall) ext_err_r[`MASCFG_ERR_STALL_BIT] <= 1'b1; // RL3
      if (int_dev_hit || ext_dev_hit) ext_err_r[`MASCFG_ERR_DEV_BIT] <= 1'b1; // RL3
    end
  end

  // Stop held while the error stands, released by read or new motion
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) motor_stop_o <= 1'b0;
    else motor_stop_o <= int_dev_hit | ext_dev_hit | ext_err_r[`MASCFG_ERR_DEV_BIT]; // RL12 RL13
  end

  // Standstill counter restarts on each step
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      still_cnt_r <= '0;
      still_r <= 1'b0;
    end else if (step_evt) begin
      still_cnt_r <= '0; // RL22
      still_r <= 1'b0;
    end else if (still_cnt_r == {STILL_LOG2{1'b1}}) begin
      still_r <= 1'b1; // RL8 RL22
    end else begin
      still_cnt_r <= still_cnt_r + 1'b1;
    end
  end

  // Current reduction timer
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pd_state_r <= MASCFG_PD_IDLE;
      pd_units_r <= 9'h0;
      pd_cyc_r <= 32'h0;
    end else if (!motor_stopped_i) begin
      pd_state_r <= MASCFG_PD_IDLE;
    end else begin
      unique case (pd_state_r)
        MASCFG_PD_IDLE: begin
          pd_units_r <= 9'h0;
          pd_cyc_r <= 32'h0;
          pd_state_r <= (pd_delay_r == 9'h0) ? MASCFG_PD_REDUCED : MASCFG_PD_WAIT; // RL15
        end
        MASCFG_PD_WAIT: begin
          // Delay lowered by the host mid-wait to the units already counted or fewer: stop waiting at once
          if (pd_units_r >= pd_delay_r) begin
            pd_state_r <= MASCFG_PD_REDUCED; // RL14
          end else if (pd_cyc_r == 32'(PD_UNIT_CYC - 1)) begin
            pd_cyc_r <= 32'h0;
            pd_units_r <= pd_units_r + 9'h1;
            if (pd_units_r + 9'h1 >= pd_delay_r) pd_state_r <= MASCFG_PD_REDUCED; // RL14
          end else begin
            pd_cyc_r <= pd_cyc_r + 32'h1;
          end
        end
        MASCFG_PD_REDUCED: pd_state_r <= MASCFG_PD_REDUCED;
      endcase
    end
  end
  assign current_reduce_o = (pd_state_r == MASCFG_PD_REDUCED);

  // Rest behaviour only applies with zero standby and silent chopper
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) rest_mode_o <= MASCFG_REST_NORMAL;
    else if (standby_zero_i && silent_chop_i && motor_stopped_i) rest_mode_o <= mascfg_rest_t'(rest_r); // RL1
    else rest_mode_o <= MASCFG_REST_NORMAL;
  end

  assign shaft_invert_o = shaft_inv_r; // RL19
  assign use_step_dir_o = src_sel_r; // RL20
  assign unit_pps_o = unit_r; // RL21

  // Read path, one cycle latency
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 32'h0;
      rvalid_o <= 1'b0;
      nak_o <= 1'b0;
    end else begin
      rvalid_o <= req_i.rd;
      nak_o <= 1'b0;
      rdata_o <= 32'h0;
      if (req_i.rd) begin
        unique case (req_i.num)
          `MASCFG_PN_STANDSTILL: rdata_o <= {30'h0, rest_r};
          `MASCFG_PN_LOAD: rdata_o <= {22'h0, load_s_r}; // RL2
          `MASCFG_PN_EXT_ERR: rdata_o <= {30'h0, ext_err_r}; // RL3
          `MASCFG_PN_DRV_FAULT: rdata_o <= {24'h0, still_r, drv.open_b, drv.open_a, drv.short_b, drv.short_a,
                                           drv.overtemp_warn, drv.overtemp, drv.stall}; // RL5 RL6 RL7 RL8
          `MASCFG_PN_INT_ENC: rdata_o <= int_enc_r;
          `MASCFG_PN_CLR_ZERO: rdata_o <= {31'h0, clr_zero_r};
          `MASCFG_PN_INT_DEV: rdata_o <= int_dev_r;
          `MASCFG_PN_PD_DELAY: rdata_o <= {23'h0, pd_delay_r};
          `MASCFG_PN_ABS_ANGLE: rdata_o <= {22'h0, angle_s_r}; // RL16
          `MASCFG_PN_EXT_ENC: rdata_o <= ext_enc_r;
          `MASCFG_PN_EXT_CPR: rdata_o <= ext_cpr_r;
          `MASCFG_PN_EXT_DEV: rdata_o <= ext_dev_r;
          `MASCFG_PN_SHAFT_INV: rdata_o <= {31'h0, shaft_inv_r};
          `MASCFG_PN_MOTION_SRC: rdata_o <= {31'h0, src_sel_r};
          `MASCFG_PN_UNIT_SEL: rdata_o <= {31'h0, unit_r};
          default: nak_o <= 1'b1;
        endcase
      end
    end
  end

  // Checks
  sequence s_rd_err;
    req_i.rd && req_i.num == `MASCFG_PN_EXT_ERR && !drv.stall && !int_dev_hit && !ext_dev_hit;
  endsequence
  property p_err_clear;
    @(posedge sys_clk_i) disable iff (rst_i) s_rd_err |=> ext_err_r == 2'b00;
  endproperty
  a_err_clear: assert property (p_err_clear) else $error("error flags not cleared by read"); // RL4
  property p_stall_flag;
    @(posedge sys_clk_i) disable iff (rst_i) drv.stall |=> ext_err_r[0];
  endproperty
  a_stall_flag: assert property (p_stall_flag) else $error("stall error flag missing"); // RL3
  property p_dev_stop;
    @(posedge sys_clk_i) disable iff (rst_i) int_dev_hit |=> motor_stop_o;
  endproperty
  a_dev_stop: assert property (p_dev_stop) else $error("deviation did not stop motor"); // RL12
  property p_ext_stop;
    @(posedge sys_clk_i) disable iff (rst_i) ext_dev_hit |=> motor_stop_o && ext_err_r[1];
  endproperty
  a_ext_stop: assert property (p_ext_stop) else $error("ext deviation did not stop motor"); // RL13
  property p_zero_off;
    @(posedge sys_clk_i) disable iff (rst_i)
      int_dev_r == 32'h0 && ext_dev_r == 32'h0 && !ext_err_r[1] |=> !motor_stop_o && !ext_err_r[1];
  endproperty
  a_zero_off: assert property (p_zero_off) else $error("zero limits did not disable the stop"); // RL12 RL13
  property p_clr_once;
    @(posedge sys_clk_i) disable iff (rst_i) clr_zero_r && pins_s[11] |=> !clr_zero_r && int_enc_r == 32'h0;
  endproperty
  a_clr_once: assert property (p_clr_once) else $error("clear on zero misbehaved"); // RL10 RL11
  property p_step_restart;
    @(posedge sys_clk_i) disable iff (rst_i) step_evt |=> !still_r && still_cnt_r == '0;
  endproperty
  a_step_restart: assert property (p_step_restart) else $error("standstill not restarted"); // RL22
  property p_pd_now;
    @(posedge sys_clk_i) disable iff (rst_i)
      pd_state_r == MASCFG_PD_IDLE && motor_stopped_i && pd_delay_r == 9'h0 |=> current_reduce_o || !motor_stopped_i;
  endproperty
  a_pd_now: assert property (p_pd_now) else $error("zero delay did not reduce at once"); // RL15
  property p_pd_wait;
    @(posedge sys_clk_i) disable iff (rst_i)
      pd_state_r == MASCFG_PD_WAIT && motor_stopped_i && pd_units_r >= pd_delay_r |=> current_reduce_o;
  endproperty
  a_pd_wait: assert property (p_pd_wait) else $error("reduction delay overrun"); // RL14
  property p_pd_hold;
    @(posedge sys_clk_i) disable iff (rst_i)
      pd_state_r == MASCFG_PD_IDLE && motor_stopped_i && pd_delay_r != 9'h0 |=> !current_reduce_o;
  endproperty
  a_pd_hold: assert property (p_pd_hold) else $error("nonzero delay reduced at once"); // RL14
  property p_rest_apply;
    @(posedge sys_clk_i) disable iff (rst_i)
      standby_zero_i && silent_chop_i && motor_stopped_i |=> rest_mode_o == $past(rest_r);
  endproperty
  a_rest_apply: assert property (p_rest_apply) else $error("rest option not applied"); // RL1
  property p_rest_normal;
    @(posedge sys_clk_i) disable iff (rst_i)
      !(standby_zero_i && silent_chop_i && motor_stopped_i) |=> rest_mode_o == MASCFG_REST_NORMAL;
  endproperty
  a_rest_normal: assert property (p_rest_normal) else $error("rest option applied out of rest"); // RL1
  property p_dev_flag;
    @(posedge sys_clk_i) disable iff (rst_i) int_dev_hit || ext_dev_hit |=> ext_err_r[1];
  endproperty
  a_dev_flag: assert property (p_dev_flag) else $error("deviation error flag missing"); // RL3
  sequence s_motion_clr;
    motion_cmd_i && !drv.stall && !int_dev_hit && !ext_dev_hit;
  endsequence
  property p_motion_clear;
    @(posedge sys_clk_i) disable iff (rst_i) s_motion_clr |=> ext_err_r == 2'b00;
  endproperty
  a_motion_clear: assert property (p_motion_clear) else $error("error flags not cleared by motion"); // RL4
  property p_err_read;
    @(posedge sys_clk_i) disable iff (rst_i)
      req_i.rd && req_i.num == `MASCFG_PN_EXT_ERR |=> rvalid_o && rdata_o == {30'h0, $past(ext_err_r)};
  endproperty
  a_err_read: assert property (p_err_read) else $error("error flags read wrong"); // RL3
  property p_drv_read;
    @(posedge sys_clk_i) disable iff (rst_i)
      req_i.rd && req_i.num == `MASCFG_PN_DRV_FAULT |=> rdata_o[31:8] == 24'h0 && rdata_o[7] == $past(still_r) &&
        rdata_o[6:0] == $past({pins_s[14], pins_s[15], pins_s[16], pins_s[17], pins_s[18], pins_s[19], pins_s[20]});
  endproperty
  a_drv_read: assert property (p_drv_read) else $error("driver fault byte read wrong"); // RL5 RL6 RL7 RL8
  property p_still_flag;
    @(posedge sys_clk_i) disable iff (rst_i) still_cnt_r == '1 && !step_evt |=> still_r;
  endproperty
  a_still_flag: assert property (p_still_flag) else $error("standstill not flagged"); // RL8 RL22
  property p_enc_count;
    @(posedge sys_clk_i) disable iff (rst_i)
      enc_evt && !(clr_zero_r && pins_s[11]) && !is_wr(req_i, `MASCFG_PN_INT_ENC) |=>
        int_enc_r == ($past(pins_s[12]) ? $past(int_enc_r) - 32'h1 : $past(int_enc_r) + 32'h1);
  endproperty
  a_enc_count: assert property (p_enc_count) else $error("encoder count step wrong"); // RL9
endmodule : mascfg_axis

// ==== test/mascfg_motor_model.sv ====
// Stand-in for the motor driver chip, the built-in encoder and the AB encoder.
// Assumes the bench calls its tasks; all pins move just after a rising clock edge.
`timescale 1ns/10ps
module mascfg_motor_model (
  // Clock
  input wire logic sys_clk_i,
  // Pins toward the axis bank
  output logic step_pin_o,
  output logic [7:0] drv_pin_o,
  output logic [9:0] load_o,
  output logic [9:0] angle_o,
  output logic int_enc_step_o,
  output logic int_enc_dir_o,
  output logic int_enc_zero_o,
  output logic ext_a_o,
  output logic ext_b_o
);
  initial begin
    step_pin_o = 1'b0;
    drv_pin_o = 8'h00;
    load_o = 10'h000;
    angle_o = 10'h000;
    int_enc_step_o = 1'b0;
    int_enc_dir_o = 1'b0;
    int_enc_zero_o = 1'b0;
    ext_a_o = 1'b0;
    ext_b_o = 1'b0;
  end

  task automatic drive(input logic [7:0] d, input logic [9:0] l, input logic [9:0] a);
    @(posedge sys_clk_i);
    drv_pin_o <= d;
    load_o <= l;
    angle_o <= a;
  endtask : drive

  // Pulses last 4 cycles so the 2-flop sampling cannot miss them
  task automatic steps(input int n);
    repeat (n) begin
      @(posedge sys_clk_i) step_pin_o <= 1'b1;
      repeat (4) @(posedge sys_clk_i);
      step_pin_o <= 1'b0;
      repeat (4) @(posedge sys_clk_i);
    end
  endtask : steps

  task automatic enc(input int n, input logic dn);
    repeat (n) begin
      @(posedge sys_clk_i) int_enc_dir_o <= dn;
      int_enc_step_o <= 1'b1;
      repeat (4) @(posedge sys_clk_i);
      int_enc_step_o <= 1'b0;
      repeat (4) @(posedge sys_clk_i);
    end
  endtask : enc

  task automatic zero();
    @(posedge sys_clk_i) int_enc_zero_o <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    int_enc_zero_o <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
  endtask : zero

  // Forward gray order 00, 01, 11, 10, one change per step; dn walks it backwards
  task automatic quad(input int n, input logic dn);
    logic [1:0] g;
    repeat (n) begin
      g = {ext_a_o, ext_b_o};
      if (dn) g = (g == 2'b00) ? 2'b10 : (g == 2'b10) ? 2'b11 : (g == 2'b11) ? 2'b01 : 2'b00;
      else g = (g == 2'b00) ? 2'b01 : (g == 2'b01) ? 2'b11 : (g == 2'b11) ? 2'b10 : 2'b00;
      @(posedge sys_clk_i) {ext_a_o, ext_b_o} <= g;
      repeat (4) @(posedge sys_clk_i);
    end
  endtask : quad
endmodule : mascfg_motor_model

// ==== test/mascfg_axis_bench.sv ====
// Self-checking bench for the axis status/config bank, driven through the parameter port.
// Assumes the motor model file is compiled first; counts shortened by parameters.
`timescale 1ns/10ps
module mascfg_axis_bench import mascfg_pkg::*; ();
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  mascfg_req_t req = '0;
  logic motion_cmd = 1'b0;
  logic [31:0] apos = 32'h0;
  logic stopped = 1'b0;
  logic sbz = 1'b0;
  logic silent = 1'b0;
  logic [31:0] rdata_o;
  logic rvalid_o, nak_o, motor_stop_o, current_reduce_o;
  logic shaft_invert_o, use_step_dir_o, unit_pps_o;
  mascfg_rest_t rest_mode_o;
  logic step, estep, edir, ezero, qa, qb;
  logic [7:0] drv;
  logic [9:0] load, angle;
  int errors = 0;
  int n_tests = 0;

  always #12.5 sys_clk_i = ~sys_clk_i;

  mascfg_axis #(.STILL_LOG2(6), .PD_UNIT_CYC(10)) u_mascfg_axis (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .req_i(req), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
    .nak_o(nak_o), .motion_cmd_i(motion_cmd), .actual_pos_i(apos), .motor_stopped_i(stopped),
    .standby_zero_i(sbz), .silent_chop_i(silent), .step_pin_i(step), .drv_pin_i(drv),
    .load_pin_i(load), .angle_pin_i(angle), .int_enc_step_i(estep), .int_enc_dir_i(edir),
    .int_enc_zero_i(ezero), .ext_a_i(qa), .ext_b_i(qb), .motor_stop_o(motor_stop_o),
    .rest_mode_o(rest_mode_o), .current_reduce_o(current_reduce_o),
    .shaft_invert_o(shaft_invert_o), .use_step_dir_o(use_step_dir_o), .unit_pps_o(unit_pps_o));

  mascfg_motor_model u_mascfg_motor_model (
    .sys_clk_i(sys_clk_i), .step_pin_o(step), .drv_pin_o(drv), .load_o(load), .angle_o(angle),
    .int_enc_step_o(estep), .int_enc_dir_o(edir), .int_enc_zero_o(ezero), .ext_a_o(qa),
    .ext_b_o(qb));

  task automatic results();
    if (errors == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask : cyc

  task automatic wr(input logic [7:0] n, input logic [31:0] d);
    @(posedge sys_clk_i) req <= '{1'b1, 1'b0, n, d};
    @(posedge sys_clk_i) req <= '0;
    #1;
  endtask : wr

  // Answer registered on the same edge that takes the request, checked 1 ns later
  task automatic rd(input logic [7:0] n);
    @(posedge sys_clk_i) req <= '{1'b0, 1'b1, n, 32'h0};
    @(posedge sys_clk_i) req <= '0;
    #1;
  endtask : rd

  task automatic rdchk(input logic [7:0] n, input logic [31:0] e);
    rd(n);
    chk(32'(rvalid_o), 32'h1);
    chk(rdata_o, e);
  endtask : rdchk

  initial begin
    repeat (5000) @(posedge sys_clk_i);
    errors++;
    results();
  end

  initial begin
    cyc(6);
    rst_i <= 1'b0;
    #1 chk(32'(unit_pps_o), 32'h1);
    rdchk(8'hD6, 32'h0);
    rdchk(8'hFF, 32'h1);
    rd(8'hCD);
    chk(32'({rvalid_o, nak_o}), 32'h3);
    chk(rdata_o, 32'h0);
    for (int v = 0; v < 2; v++) begin
      wr(8'hFB, 32'(v));
      wr(8'hFE, 32'(v));
      wr(8'hFF, 32'(v));
      chk(32'({shaft_invert_o, use_step_dir_o, unit_pps_o}), v ? 32'h7 : 32'h0);
    end
    // Standstill flag still clear just after a step, then set once the counter saturates
    u_mascfg_motor_model.steps(1);
    u_mascfg_motor_model.drive(8'h00, 10'h3FF, 10'h2A5);
    rdchk(8'hD0, 32'h0);
    cyc(80);
    rdchk(8'hD0, 32'h80);
    for (int i = 0; i < 7; i++) begin
      u_mascfg_motor_model.drive(8'h01 << (6 - i), 10'h3FF, 10'h2A5);
      cyc(4);
      rdchk(8'hD0, 32'h80 | (32'h1 << i));
    end
    u_mascfg_motor_model.drive(8'h00, 10'h3FF, 10'h2A5);
    wr(8'hCE, 32'h0);
    rdchk(8'hCE, 32'h3FF);
    rdchk(8'hD7, 32'h2A5);
    rdchk(8'hCF, 32'h1);
    rdchk(8'hCF, 32'h0);
    wr(8'hD1, 32'hFFFFFFF0);
    u_mascfg_motor_model.enc(3, 1'b0);
    rdchk(8'hD1, 32'hFFFFFFF3);
    u_mascfg_motor_model.enc(5, 1'b1);
    rdchk(8'hD1, 32'hFFFFFFEE);
    wr(8'hD2, 32'h1);
    rdchk(8'hD2, 32'h1);
    u_mascfg_motor_model.zero();
    rdchk(8'hD1, 32'h0);
    rdchk(8'hD2, 32'h0);
    u_mascfg_motor_model.enc(2, 1'b0);
    u_mascfg_motor_model.zero();
    rdchk(8'hD1, 32'h2);
    wr(8'hD8, 32'h64);
    u_mascfg_motor_model.quad(8, 1'b0);
    rdchk(8'hD8, 32'h6C);
    u_mascfg_motor_model.quad(3, 1'b1);
    rdchk(8'hD8, 32'h69);
    wr(8'hD9, 32'hFFFFFFFF);
    rdchk(8'hD9, 32'h7FFFFFFF);
    // Deviation limits: equal to the limit is still fine
    wr(8'hD1, 32'h0);
    wr(8'hD8, 32'h0);
    wr(8'hDA, 32'h0);
    wr(8'hD4, 32'h5);
    @(posedge sys_clk_i) apos <= 32'h5;
    cyc(4);
    #1 chk(32'(motor_stop_o), 32'h0);
    @(posedge sys_clk_i) apos <= 32'h6;
    cyc(4);
    #1 chk(32'(motor_stop_o), 32'h1);
    @(posedge sys_clk_i) apos <= 32'h0;
    cyc(4);
    #1 chk(32'(motor_stop_o), 32'h1);
    rdchk(8'hCF, 32'h2);
    cyc(2);
    #1 chk(32'(motor_stop_o), 32'h0);
    wr(8'hD4, 32'h0);
    @(posedge sys_clk_i) apos <= 32'hFFFFFC18;
    cyc(4);
    #1 chk(32'(motor_stop_o), 32'h0);
    wr(8'hDA, 32'h5);
    @(posedge sys_clk_i) apos <= 32'hFFFFFFFA;
    cyc(4);
    #1 chk(32'(motor_stop_o), 32'h1);
    @(posedge sys_clk_i) apos <= 32'h0;
    cyc(4);
    @(posedge sys_clk_i) motion_cmd <= 1'b1;
    @(posedge sys_clk_i) motion_cmd <= 1'b0;
    cyc(2);
    #1 chk(32'(motor_stop_o), 32'h0);
    rdchk(8'hCF, 32'h0);
    @(posedge sys_clk_i) stopped <= 1'b1;
    sbz <= 1'b1;
    silent <= 1'b1;
    for (int m = 0; m < 4; m++) begin
      wr(8'hCC, 32'(m));
      cyc(2);
      #1 chk(32'(rest_mode_o), 32'(m));
    end
    @(posedge sys_clk_i) silent <= 1'b0;
    cyc(2);
    #1 chk(32'(rest_mode_o), 32'h0);
    chk(32'(current_reduce_o), 32'h1);
    @(posedge sys_clk_i) stopped <= 1'b0;
    cyc(3);
    #1 chk(32'(current_reduce_o), 32'h0);
    wr(8'hD6, 32'h3);
    rdchk(8'hD6, 32'h3);
    @(posedge sys_clk_i) stopped <= 1'b1;
    cyc(25);
    #1 chk(32'(current_reduce_o), 32'h0);
    cyc(10);
    #1 chk(32'(current_reduce_o), 32'h1);
    // Delay lowered while waiting ends the wait early
    @(posedge sys_clk_i) stopped <= 1'b0;
    cyc(2);
    @(posedge sys_clk_i) stopped <= 1'b1;
    cyc(15);
    wr(8'hD6, 32'h1);
    cyc(2);
    #1 chk(32'(current_reduce_o), 32'h1);
    results();
  end
endmodule : mascfg_axis_bench
